// file: design/cpu_sys_consts.svh
`ifndef CPU_SYS_CONSTS_SVH
`define CPU_SYS_CONSTS_SVH
// Register addresses in the register file
`define WPL_ADDR          8'hE8
`define WPH_ADDR          8'hE9
`define PPS_ADDR          8'hEA
`define CMC_ADDR          8'hEB
`define USPH_ADDR         8'hEC
`define USPL_ADDR         8'hED
`define SSPH_ADDR         8'hEE
`define SSPL_ADDR         8'hEF
// Field positions
`define BLOCK_MSB         7
`define BLOCK_LSB         3
`define PTR_MODE_BIT      2
`define PAGE_MSB          7
`define PAGE_LSB          2
`define SYS_STK_BIT       7
`define USR_STK_BIT       6
`define HALVE_BIT         5
`define DIV_MSB           4
`define DIV_LSB           2
`define BRQ_EN_BIT        1
`define FLOAT_BIT         0
// Reset values
`define CMC_RESET         8'hE0
`define PTR_RESET         8'h00
`define SP_RESET          16'h0000
`endif

// file: design/cpu_sys_pkg.sv
`default_nettype none
package cpu_sys_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    STK_NONE = 3'h0,
    STK_PUSH = 3'h1,
    STK_POP  = 3'h2
  } stk_op_e;
endpackage
`default_nettype wire

// file: design/clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
// Divide-by-(ratio+1) pulse generator; one pulse of one cycle per period
module clock_divider (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic [2:0] ratio_i,
  output logic            tick_o
);
  logic [2:0] count_ff;
  logic [2:0] nxt_count;
  logic       tick_ff;
  logic       nxt_tick;

  always_comb begin
    if (count_ff >= ratio_i) begin
      nxt_count = 3'h0;
      nxt_tick  = 1'h1;
    end else begin
      nxt_count = count_ff + 3'h1;
      nxt_tick  = 1'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      count_ff <= 3'h0;
      tick_ff  <= 1'h0;
    end else begin
      count_ff <= nxt_count;
      tick_ff  <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;
endmodule // clock_divider
`default_nettype wire

// file: design/stack_pointer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_sys_consts.svh"
// One stack pointer: pre-decrement push, post-increment pop
module stack_pointer (
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  wire logic              in_regfile_i,
  input  wire logic              wr_hi_i,
  input  wire logic              wr_lo_i,
  input  wire logic [7:0]        wdata_i,
  input  wire cpu_sys_pkg::stk_op_e op_i,
  input  wire logic              word_i,
  output logic [15:0]            ptr_o,
  output logic [15:0]            access_addr_o
);
  import cpu_sys_pkg::*;
  word_t ptr_ff;
  word_t nxt_ptr;
  word_t step;
  word_t dec_ptr;

  always_comb begin
    step    = word_i ? 16'h0002 : 16'h0001;
    dec_ptr = ptr_ff - step;
    nxt_ptr = ptr_ff;
    if (wr_hi_i) begin
      nxt_ptr[15:8] = wdata_i;
    end
    if (wr_lo_i) begin
      nxt_ptr[7:0] = wdata_i;
    end
    unique case (op_i)
      STK_PUSH: nxt_ptr = dec_ptr;
      STK_POP:  nxt_ptr = ptr_ff + step;
      default:  ;
    endcase
    if (in_regfile_i) begin
      nxt_ptr[15:8] = ptr_ff[15:8];
      if (wr_hi_i) begin
        nxt_ptr[15:8] = wdata_i;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ptr_ff <= `SP_RESET;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  assign ptr_o = ptr_ff;
  // Push writes at the decremented address; pop reads at the current one
  always_comb begin
    if (op_i == STK_PUSH) begin
      access_addr_o = in_regfile_i ? {8'h00, dec_ptr[7:0]} : dec_ptr;
    end else begin
      access_addr_o = in_regfile_i ? {8'h00, ptr_ff[7:0]} : ptr_ff;
    end
  end
endmodule // stack_pointer
`default_nettype wire

// file: design/cpu_system_pointer_mode_regs.sv
// Functional notes
// - First pointer bits 7:3 hold block 0..31 from single or first-twin set.
// - Single mode maps 16 registers at first block; twin maps r0..r7 there.
// - Twin set instructions set mode bit 2 in both pointers; single clears.
// - Bits 1:0 of both pointers and page select always read zero.
// - Second pointer bits 7:3 hold second-twin block; maps r8..r15.
// - Page select bits 7:2 hold page 0..63 until changed.
// - Up to 64 pages of 16 registers; absent peripherals have none.
// - Page select is not stacked on interrupt entry.
// - Mode bit 7 places system stack in register file when set.
// - Mode bit 6 places user stack in register file when set.
// - Mode bit 5 halves crystal clock when set.
// - Mode bits 4:2 set core clock prescaler, divide 1 to 8.
// - Mode bit 1 enables bus request pin; otherwise ignored.
// - Mode bit 0 floats memory bus and strobes, not general I/O.
// - Stack pointers pre-decrement on push, post-increment on pop.
// - Pop leaves stack contents untouched.
// - Interrupt entry pushes PC, flags, and segment if enabled.
// - Call pushes PC; segment call also pushes segment; returns match.
// - Push/pop default system stack; user and word options combine.
// - Register-file stacks use only pointer low byte.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_sys_consts.svh"
module cpu_system_pointer_mode_regs (
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  // Register-file access from the core
  input  wire logic              reg_wr_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire cpu_sys_pkg::byte_t reg_wdata_i,
  output cpu_sys_pkg::byte_t     reg_rdata_o,
  output logic                   reg_hit_o,
  // Pointer set instructions
  input  wire logic              set_single_instr_i,
  input  wire logic              set_first_twin_instr_i,
  input  wire logic              set_second_twin_instr_i,
  input  wire logic              set_page_instr_i,
  input  wire logic [7:0]        instr_operand_i,
  // Working register decode
  input  wire logic [3:0]        work_reg_i,
  output logic [7:0]             work_reg_addr_o,
  output logic [5:0]             page_number_o,
  // Stack operations
  input  wire logic              push_i,
  input  wire logic              pop_i,
  input  wire logic              user_stack_i,
  input  wire logic              word_i,
  input  wire logic              irq_entry_i,
  input  wire logic              call_i,
  input  wire logic              segment_call_i,
  input  wire logic              return_i,
  input  wire logic              segment_push_enable_i,
  output logic [2:0]             auto_push_items_o,
  output logic [2:0]             auto_pop_items_o,
  output logic [15:0]            sys_stack_addr_o,
  output logic [15:0]            usr_stack_addr_o,
  output logic                   stack_wr_o,
  output logic                   sys_stack_in_regfile_o,
  output logic                   usr_stack_in_regfile_o,
  // Clocking and external bus
  output logic                   crystal_halving_o,
  output logic [2:0]             core_clock_divider_o,
  output logic                   core_clock_tick_o,
  input  wire logic              bus_request_pin_n_i,
  output logic                   bus_request_o,
  output logic                   memory_bus_float_o
);
  import cpu_sys_pkg::*;

  byte_t   wpl_ff;
  byte_t   nxt_wpl;
  byte_t   wph_ff;
  byte_t   nxt_wph;
  byte_t   pps_ff;
  byte_t   nxt_pps;
  byte_t   cmc_ff;
  byte_t   nxt_cmc;
  logic    bus_request_pin_meta_ff;
  logic    bus_request_pin_sync_ff;
  logic    bus_request_pin_ff;
  logic    nxt_bus_request_pin;
  logic [2:0] push_items_ff;
  logic [2:0] nxt_push_items;
  logic [2:0] pop_items_ff;
  logic [2:0] nxt_pop_items;
  stk_op_e sys_op;
  stk_op_e usr_op;
  word_t   system_stack_location;
  word_t   user_stack_location;
  logic    mode_twin;

  assign mode_twin = wpl_ff[`PTR_MODE_BIT];

  always_comb begin
    nxt_wpl = wpl_ff;
    nxt_wph = wph_ff;
    nxt_pps = pps_ff;
    nxt_cmc = cmc_ff;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `WPL_ADDR: nxt_wpl = reg_wdata_i;
        `WPH_ADDR: nxt_wph = reg_wdata_i;
        `PPS_ADDR: nxt_pps = reg_wdata_i;
        `CMC_ADDR: nxt_cmc = reg_wdata_i;
        default:   ;
      endcase
    end
    if (set_single_instr_i || set_first_twin_instr_i) begin
      nxt_wpl[`BLOCK_MSB:`BLOCK_LSB] = instr_operand_i[4:0];
    end
    if (set_second_twin_instr_i) begin
      nxt_wph[`BLOCK_MSB:`BLOCK_LSB] = instr_operand_i[4:0];
    end
    if (set_first_twin_instr_i || set_second_twin_instr_i) begin
      nxt_wpl[`PTR_MODE_BIT] = 1'h1;
      nxt_wph[`PTR_MODE_BIT] = 1'h1;
    end else if (set_single_instr_i) begin
      nxt_wpl[`PTR_MODE_BIT] = 1'h0;
      nxt_wph[`PTR_MODE_BIT] = 1'h0;
    end
    if (set_page_instr_i) begin
      nxt_pps[`PAGE_MSB:`PAGE_LSB] = instr_operand_i[5:0];
    end
    nxt_wpl[1:0] = 2'h0;
    nxt_wph[1:0] = 2'h0;
    nxt_pps[1:0] = 2'h0;
  end

  // Pointer block fields are undefined at reset; cleared for determinism
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wpl_ff <= `PTR_RESET;
      wph_ff <= `PTR_RESET;
      pps_ff <= `PTR_RESET;
      cmc_ff <= `CMC_RESET;
    end else begin
      wpl_ff <= nxt_wpl;
      wph_ff <= nxt_wph;
      pps_ff <= nxt_pps;
      cmc_ff <= nxt_cmc;
    end
  end

  always_comb begin
    reg_hit_o = 1'h1;
    unique case (reg_addr_i)
      `WPL_ADDR:  reg_rdata_o = wpl_ff;
      `WPH_ADDR:  reg_rdata_o = wph_ff;
      `PPS_ADDR:  reg_rdata_o = pps_ff;
      `CMC_ADDR:  reg_rdata_o = cmc_ff;
      `USPH_ADDR: reg_rdata_o = user_stack_location[15:8];
      `USPL_ADDR: reg_rdata_o = user_stack_location[7:0];
      `SSPH_ADDR: reg_rdata_o = system_stack_location[15:8];
      `SSPL_ADDR: reg_rdata_o = system_stack_location[7:0];
      default: begin
        reg_rdata_o = 8'h00;
        reg_hit_o   = 1'h0;
      end
    endcase
  end

  always_comb begin
    if (!mode_twin) begin
      // Odd block rounds down to a 16-register boundary
      work_reg_addr_o = {wpl_ff[`BLOCK_MSB:`BLOCK_LSB+1], work_reg_i};
    end else if (!work_reg_i[3]) begin
      work_reg_addr_o = {wpl_ff[`BLOCK_MSB:`BLOCK_LSB], work_reg_i[2:0]};
    end else begin
      work_reg_addr_o = {wph_ff[`BLOCK_MSB:`BLOCK_LSB], work_reg_i[2:0]};
    end
  end

  // Page number to paged group decoder
  assign page_number_o = pps_ff[`PAGE_MSB:`PAGE_LSB];

  always_comb begin
    sys_op = STK_NONE;
    usr_op = STK_NONE;
    if (push_i) begin
      if (user_stack_i) begin
        usr_op = STK_PUSH;
      end else begin
        sys_op = STK_PUSH;
      end
    end else if (pop_i) begin
      if (user_stack_i) begin
        usr_op = STK_POP;
      end else begin
        sys_op = STK_POP;
      end
    end
  end

  assign stack_wr_o = push_i;

  assign sys_stack_in_regfile_o = cmc_ff[`SYS_STK_BIT];
  assign usr_stack_in_regfile_o = cmc_ff[`USR_STK_BIT];

  stack_pointer u_sys_sp (
    .clock_i       (clock_i),
    .sys_rst_i     (sys_rst_i),
    .in_regfile_i  (cmc_ff[`SYS_STK_BIT]),
    .wr_hi_i       (reg_wr_i && (reg_addr_i == `SSPH_ADDR)),
    .wr_lo_i       (reg_wr_i && (reg_addr_i == `SSPL_ADDR)),
    .wdata_i       (reg_wdata_i),
    .op_i          (sys_op),
    .word_i        (word_i),
    .ptr_o         (system_stack_location),
    .access_addr_o (sys_stack_addr_o)
  );

  stack_pointer u_usr_sp (
    .clock_i       (clock_i),
    .sys_rst_i     (sys_rst_i),
    .in_regfile_i  (cmc_ff[`USR_STK_BIT]),
    .wr_hi_i       (reg_wr_i && (reg_addr_i == `USPH_ADDR)),
    .wr_lo_i       (reg_wr_i && (reg_addr_i == `USPL_ADDR)),
    .wdata_i       (reg_wdata_i),
    .op_i          (usr_op),
    .word_i        (word_i),
    .ptr_o         (user_stack_location),
    .access_addr_o (usr_stack_addr_o)
  );

  // Items count: bit0 PC, bit1 flags, bit2 segment
  always_comb begin
    nxt_push_items = 3'h0;
    nxt_pop_items  = 3'h0;
    if (irq_entry_i) begin
      nxt_push_items = {segment_push_enable_i, 2'h3};
    end else if (segment_call_i) begin
      nxt_push_items = 3'h5;
    end else if (call_i) begin
      nxt_push_items = 3'h1;
    end
    if (return_i) begin
      nxt_pop_items = segment_call_i ? 3'h5 : 3'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      push_items_ff <= 3'h0;
      pop_items_ff  <= 3'h0;
    end else begin
      push_items_ff <= nxt_push_items;
      pop_items_ff  <= nxt_pop_items;
    end
  end

  assign auto_push_items_o = push_items_ff;
  assign auto_pop_items_o  = pop_items_ff;

  assign crystal_halving_o = cmc_ff[`HALVE_BIT];
  assign core_clock_divider_o = cmc_ff[`DIV_MSB:`DIV_LSB];

  clock_divider u_prescaler (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ratio_i   (cmc_ff[`DIV_MSB:`DIV_LSB]),
    .tick_o    (core_clock_tick_o)
  );

  // Pin is asynchronous, so two stages before use
  always_comb begin
    nxt_bus_request_pin = cmc_ff[`BRQ_EN_BIT] && !bus_request_pin_sync_ff;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bus_request_pin_meta_ff <= 1'h1;
      bus_request_pin_sync_ff <= 1'h1;
      bus_request_pin_ff      <= 1'h0;
    end else begin
      bus_request_pin_meta_ff <= bus_request_pin_n_i;
      bus_request_pin_sync_ff <= bus_request_pin_meta_ff;
      bus_request_pin_ff      <= nxt_bus_request_pin;
    end
  end

  assign bus_request_o = bus_request_pin_ff;

  assign memory_bus_float_o = cmc_ff[`FLOAT_BIT];
endmodule // cpu_system_pointer_mode_regs
`default_nettype wire

// file: sim/cpu_sys_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_sys_consts.svh"
module cpu_sys_regs_chk (
  input wire logic               clock_i,
  input wire logic               sys_rst_i,
  input wire logic               reg_wr_i,
  input wire logic [7:0]         reg_addr_i,
  input wire cpu_sys_pkg::byte_t reg_wdata_i,
  input wire cpu_sys_pkg::byte_t reg_rdata_o,
  input wire logic               reg_hit_o,
  input wire logic               set_single_instr_i,
  input wire logic               set_first_twin_instr_i,
  input wire logic               set_second_twin_instr_i,
  input wire logic               set_page_instr_i,
  input wire logic [7:0]         instr_operand_i,
  input wire logic [3:0]         work_reg_i,
  input wire logic [7:0]         work_reg_addr_o,
  input wire logic [5:0]         page_number_o,
  input wire logic               push_i,
  input wire logic               pop_i,
  input wire logic               user_stack_i,
  input wire logic               word_i,
  input wire logic               irq_entry_i,
  input wire logic               call_i,
  input wire logic               segment_call_i,
  input wire logic               return_i,
  input wire logic               segment_push_enable_i,
  input wire logic [2:0]         auto_push_items_o,
  input wire logic [15:0]        sys_stack_addr_o,
  input wire logic               sys_stack_in_regfile_o,
  input wire logic               usr_stack_in_regfile_o,
  input wire logic               crystal_halving_o,
  input wire logic [2:0]         core_clock_divider_o,
  input wire logic               bus_request_pin_n_i,
  input wire logic               bus_request_o,
  input wire logic               memory_bus_float_o
);
  import cpu_sys_pkg::*;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_reset_mode: assert property (
    $fell(sys_rst_i) |-> {sys_stack_in_regfile_o, usr_stack_in_regfile_o, page_number_o} == 8'hC0)
    else $error("mode or page wrong after reset");
  chk_low_bits: assert property (
    reg_addr_i inside {`WPL_ADDR, `WPH_ADDR, `PPS_ADDR} |-> reg_hit_o && reg_rdata_o[1:0] == 2'h0)
    else $error("pointer low bits not zero");
  chk_first_twin: assert property (
    set_first_twin_instr_i |=> work_reg_i[3] ||
    work_reg_addr_o == {$past(instr_operand_i[4:0]), work_reg_i[2:0]})
    else $error("twin low group mapped wrong");
  chk_single_map: assert property (
    set_single_instr_i && !set_first_twin_instr_i && !set_second_twin_instr_i
    |=> work_reg_addr_o == {$past(instr_operand_i[4:1]), work_reg_i}) else $error("single mapping wrong");
  chk_second_twin: assert property (
    set_second_twin_instr_i |=> !work_reg_i[3] ||
    work_reg_addr_o == {$past(instr_operand_i[4:0]), work_reg_i[2:0]})
    else $error("twin high group mapped wrong");
  chk_page_load: assert property (
    set_page_instr_i |=> page_number_o == $past(instr_operand_i[5:0])) else $error("page not loaded");
  chk_page_hold: assert property (
    !set_page_instr_i && !(reg_wr_i && reg_addr_i == `PPS_ADDR) |=> $stable(page_number_o))
    else $error("page changed without cause");
  chk_pop_incr: assert property (
    pop_i && !push_i && !user_stack_i && !word_i && !reg_wr_i
    |=> push_i || sys_stack_addr_o[7:0] == $past(sys_stack_addr_o[7:0]) + 8'h01) else $error("pop step wrong");
  chk_irq_items: assert property (
    irq_entry_i && !call_i && !segment_call_i |=> auto_push_items_o == {$past(segment_push_enable_i), 2'h3})
    else $error("interrupt items wrong");
  chk_call_items: assert property (
    (call_i || segment_call_i) && !irq_entry_i && !return_i |=> auto_push_items_o == {$past(segment_call_i), 2'h1})
    else $error("call items wrong");
  chk_bus_request_pin_idle: assert property (
    bus_request_pin_n_i [*5] |-> !bus_request_o) else $error("bus request without pin");
  chk_mode_write: assert property (
    reg_wr_i && reg_addr_i == `CMC_ADDR |=> {sys_stack_in_regfile_o, usr_stack_in_regfile_o, crystal_halving_o,
    core_clock_divider_o, memory_bus_float_o} == {$past(reg_wdata_i[7:2]), $past(reg_wdata_i[0])})
    else $error("mode outputs do not follow write");
endmodule // cpu_sys_regs_chk

bind cpu_system_pointer_mode_regs cpu_sys_regs_chk u_chk (.*);
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_sys_consts.svh"
module tb_top;
  import cpu_sys_pkg::*;
  logic        clock_i, sys_rst_i, reg_wr_i, bus_request_pin_n_i, reg_hit_o, stack_wr_o, core_clock_tick_o;
  logic        sys_stack_in_regfile_o, usr_stack_in_regfile_o, crystal_halving_o, bus_request_o, memory_bus_float_o;
  logic [7:0]  reg_addr_i, instr_operand_i, work_reg_addr_o;
  byte_t       reg_wdata_i, reg_rdata_o;
  logic [3:0]  work_reg_i, set_v, sk;
  logic [4:0]  ev;
  logic [5:0]  page_number_o;
  logic [2:0]  auto_push_items_o, auto_pop_items_o, core_clock_divider_o;
  logic [15:0] sys_stack_addr_o, usr_stack_addr_o;
  wire logic   set_single_instr_i, set_first_twin_instr_i, set_second_twin_instr_i, set_page_instr_i;
  wire logic   push_i, pop_i, user_stack_i, word_i;
  wire logic   irq_entry_i, call_i, segment_call_i, return_i, segment_push_enable_i;
  int          num_errors = 0;
  int          n_compared = 0;

  assign {set_page_instr_i, set_second_twin_instr_i, set_first_twin_instr_i, set_single_instr_i} = set_v;
  assign {push_i, pop_i, user_stack_i, word_i} = sk;
  assign {irq_entry_i, call_i, segment_call_i, return_i, segment_push_enable_i} = ev;

  cpu_system_pointer_mode_regs dut (.*);

  always #2.5 clock_i = ~clock_i;

  task automatic final_report();
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
    @(negedge clock_i);
    reg_wr_i = 1'b0;
  endtask

  // Read data is combinational, so it is judged mid-cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock_i);
    reg_addr_i = a;
    #1 chk("reg_rdata_o", 16'(e), 16'(reg_rdata_o));
    chk("reg_hit_o", 16'(a inside {[8'hE8:8'hEF]}), 16'(reg_hit_o));
  endtask

  task automatic ins(input int k, input logic [7:0] op);
    @(negedge clock_i);
    set_v = 4'(1 << k);
    instr_operand_i = op;
    @(negedge clock_i);
    set_v = 4'h0;
  endtask

  task automatic wra(input logic [3:0] r, input logic [7:0] e);
    @(negedge clock_i);
    work_reg_i = r;
    #1 chk("work_reg_addr_o", 16'(e), 16'(work_reg_addr_o));
  endtask

  // Stack op bits: push, pop, user, word; addresses seen during the op
  task automatic stk(input logic [3:0] s, input logic [15:0] es, input logic [15:0] eu);
    @(negedge clock_i);
    sk = s;
    #1 chk("sys_stack_addr_o", es, sys_stack_addr_o);
    chk("usr_stack_addr_o", eu, usr_stack_addr_o);
    chk("stack_wr_o", 16'(s[3]), 16'(stack_wr_o));
    @(negedge clock_i);
    sk = 4'h0;
  endtask

  task automatic t_reset();
    rd(`WPL_ADDR, 8'h00);
    rd(`WPH_ADDR, 8'h00);
    rd(`PPS_ADDR, 8'h00);
    rd(`CMC_ADDR, 8'hE0);
    rd(8'hE7, 8'h00);
  endtask

  task automatic t_ptr();
    ins(1, 8'h05);
    rd(`WPL_ADDR, 8'h2C);
    rd(`WPH_ADDR, 8'h04);
    wra(4'h3, 8'h2B);
    wra(4'h9, 8'h01);
    ins(2, 8'h1F);
    rd(`WPH_ADDR, 8'hFC);
    wra(4'h9, 8'hF9);
    wra(4'h2, 8'h2A);
    wr(`WPH_ADDR, 8'hFF);
    rd(`WPH_ADDR, 8'hFC);
    ins(0, 8'h03);
    rd(`WPL_ADDR, 8'h18);
    rd(`WPH_ADDR, 8'hF8);
    wra(4'hF, 8'h1F);
    wr(`WPL_ADDR, 8'hFF);
    rd(`WPL_ADDR, 8'hFC);
  endtask

  task automatic t_page();
    ins(3, 8'h3F);
    chk("page_number_o", 16'h003F, 16'(page_number_o));
    rd(`PPS_ADDR, 8'hFC);
    wr(`PPS_ADDR, 8'h17);
    rd(`PPS_ADDR, 8'h14);
    chk("page_number_o", 16'h0005, 16'(page_number_o));
  endtask

  // Cause, pushed items, popped items
  task automatic t_items();
    logic [10:0] tab [6];
    tab = '{11'b10000_011_000, 11'b10001_111_000, 11'b01000_001_000,
            11'b00100_101_000, 11'b00010_000_001, 11'b00110_000_101};
    foreach (tab[i]) begin
      @(negedge clock_i);
      ev = tab[i][10:6];
      @(negedge clock_i);
      ev = 5'h0;
      if (!tab[i][7])
        chk("auto_push_items_o", 16'(tab[i][5:3]), 16'(auto_push_items_o));
      chk("auto_pop_items_o", 16'(tab[i][2:0]), 16'(auto_pop_items_o));
    end
    chk("page_number_o", 16'h0005, 16'(page_number_o));
  endtask

  task automatic t_mode();
    wr(`CMC_ADDR, 8'h1F);
    chk("mode outputs", 16'h000F, 16'({sys_stack_in_regfile_o, usr_stack_in_regfile_o, crystal_halving_o,
        core_clock_divider_o, memory_bus_float_o}));
    rd(`CMC_ADDR, 8'h1F);
    wr(`CMC_ADDR, 8'hE0);
    chk("mode outputs", 16'h0070, 16'({sys_stack_in_regfile_o, usr_stack_in_regfile_o, crystal_halving_o,
        core_clock_divider_o, memory_bus_float_o}));
  endtask

  // Period is measured between two later ticks, since the first may carry the old phase
  task automatic t_prescale();
    int c;
    for (int n = 0; n < 8; n++) begin
      wr(`CMC_ADDR, 8'hE0 | 8'(n << 2));
      c = 0;
      while (core_clock_tick_o !== 1'b1 && c < 20) begin
        @(negedge clock_i);
        c++;
      end
      repeat (2) begin
        c = 0;
        do begin
          @(negedge clock_i);
          c++;
        end while (core_clock_tick_o !== 1'b1 && c < 20);
      end
      chk("tick period", 16'(n + 1), 16'(c));
    end
  endtask

  task automatic t_busreq();
    wr(`CMC_ADDR, 8'hE0);
    bus_request_pin_n_i = 1'b0;
    repeat (6) @(negedge clock_i);
    chk("bus_request_o", 16'h0000, 16'(bus_request_o));
    wr(`CMC_ADDR, 8'hE2);
    repeat (6) @(negedge clock_i);
    chk("bus_request_o", 16'h0001, 16'(bus_request_o));
    bus_request_pin_n_i = 1'b1;
    repeat (6) @(negedge clock_i);
    chk("bus_request_o", 16'h0000, 16'(bus_request_o));
    wr(`CMC_ADDR, 8'hE0);
  endtask

  task automatic t_stack();
    wr(`SSPL_ADDR, 8'h40);
    wr(`USPL_ADDR, 8'h80);
    stk(4'h8, 16'h003F, 16'h0080);
    stk(4'h9, 16'h003D, 16'h0080);
    stk(4'h5, 16'h003D, 16'h0080);
    stk(4'h4, 16'h003F, 16'h0080);
    stk(4'hA, 16'h0040, 16'h007F);
    stk(4'h0, 16'h0040, 16'h007F);
    wr(`SSPH_ADDR, 8'h12);
    stk(4'h8, 16'h003F, 16'h007F);
    rd(`SSPH_ADDR, 8'h12);
    wr(`CMC_ADDR, 8'h20);
    wr(`SSPL_ADDR, 8'h00);
    stk(4'h8, 16'h11FF, 16'h007F);
    rd(`SSPH_ADDR, 8'h11);
    rd(`SSPL_ADDR, 8'hFF);
  endtask

  initial begin
    clock_i = 1'b0;
    {sys_rst_i, reg_wr_i, bus_request_pin_n_i} = 3'b101;
    {set_v, sk, ev, work_reg_i} = '0;
    {reg_addr_i, instr_operand_i, reg_wdata_i} = '0;
    repeat (20) @(negedge clock_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_ptr();
    t_page();
    t_items();
    t_mode();
    t_prescale();
    t_busreq();
    t_stack();
    final_report();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
